// *** shared/dither_ram_pkg.sv ***
package dither_ram_pkg;
   localparam int ADDR_W = 6;
   localparam int DEPTH = 64;
   localparam int DATA_W = 32;
   localparam int CRC_W = 24;
   localparam int FRAME_W = 8;
   // Control register layout
   localparam int ACCESS_BIT = 7;
   localparam int UPDATE_BIT = 6;
   localparam int ADDR_LSB = 0;
   // Signature register layout
   localparam int CRC_LSB = 0;
   localparam int FRAME_LSB = 24;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
   localparam logic RVALID_RESET = 1'h0;
   localparam logic POWER_DOWN_RESET = 1'h1;

   typedef enum logic [1:0] {
      SEL_CTRL,
      SEL_DATA,
      SEL_SIG,
      SEL_NONE
   } reg_sel_t;

   typedef struct packed {
      logic wr;
      logic rd;
      reg_sel_t sel;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [CRC_W-1:0] crc;
      logic [FRAME_W-1:0] frames;
   } sig_in_t;
endpackage

// *** hw/dither_ram_host_access.sv ***
// What this block does
// RULE1: Access-enable bit low blocks all host RAM reads and writes; high permits them.
// RULE2: Software sets control bits 7, 6 and external bits 12, 0 before access.
// RULE3: Any of the four enables clear powers the RAM down and blocks access.
// RULE4: Update-enable together with access-enable decides whether writes change RAM contents.
// RULE5: A 6-bit address field picks the location the next data access uses.
// RULE6: Each data register read or write advances the address pointer by one.
// RULE7: Software reloads the address before any non-sequential access.
// RULE8: The data register carries one full 32-bit word each way.
// RULE9: Signature register shows read-only 24-bit CRC plus a frame count.
// RULE10: Pointer stays put when a data access arrives while access is disabled.
`timescale 1ns/10ps
module dither_ram_host_access (
   input wire logic clk,
   input wire logic srst,
   input wire dither_ram_pkg::reg_req_t req,
   input wire logic panel_ctl_bit12,
   input wire logic panel_ctl_bit0,
   input wire dither_ram_pkg::sig_in_t sig_in,
   output logic [dither_ram_pkg::DATA_W-1:0] rdata,
   output logic rvalid,
   output logic ram_power_down
);
   import dither_ram_pkg::*;

   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] next_mem [DEPTH];
   logic [DATA_W-1:0] next_rdata;
   logic next_rvalid;
   logic next_power_down;
   logic all_enabled;
   logic data_access;
   logic ctrl_wr;
   logic ctrl_rd;
   logic data_wr;
   logic data_rd;
   logic sig_rd;
   logic none_rd;
   logic access_ok;
   logic write_commit;
   logic [ADDR_W-1:0] ptr;
   logic [ADDR_W-1:0] ptr_step;
   logic [DATA_W-1:0] cur_word;
   logic [DATA_W-1:0] sig_word;

   // Register decode; the select field names at most one register, none for SEL_NONE
   assign ctrl_wr = req.wr && req.sel == SEL_CTRL;
   assign ctrl_rd = req.rd && req.sel == SEL_CTRL;
   assign data_wr = req.wr && req.sel == SEL_DATA;
   assign data_rd = req.rd && req.sel == SEL_DATA;
   assign sig_rd = req.rd && req.sel == SEL_SIG;
   assign none_rd = req.rd && req.sel == SEL_NONE;
   assign data_access = data_wr | data_rd;

   assign ptr = ctrl[ADDR_LSB +: ADDR_W];
   // Wraps from the last word back to the first
   assign ptr_step = ptr + 6'h01;
   // All four enables must be high; external pair arrives on this clock
   assign all_enabled = ctrl[ACCESS_BIT] & ctrl[UPDATE_BIT] & panel_ctl_bit12 & panel_ctl_bit0; // RULE3
   assign access_ok = data_access && all_enabled && ctrl[ACCESS_BIT]; // RULE1
   // Update bit and access bit both gate the write
   assign write_commit = data_wr && all_enabled && ctrl[UPDATE_BIT] && ctrl[ACCESS_BIT]; // RULE4
   assign cur_word = mem[ptr]; // RULE5

   always_comb begin
      sig_word = RDATA_RESET;
      sig_word[CRC_LSB +: CRC_W] = sig_in.crc; // RULE9
      sig_word[FRAME_LSB +: FRAME_W] = sig_in.frames;
   end

   // Control group: a control write wins over the pointer step
   always_comb begin
      next_ctrl = ctrl;
      if (ctrl_wr) begin
         next_ctrl = req.wdata[7:0];
      end else if (access_ok) begin
         next_ctrl[ADDR_LSB +: ADDR_W] = ptr_step; // RULE6 RULE10
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl <= CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // Read group: rdata holds between reads, rvalid pulses once
   always_comb begin
      next_rdata = rdata;
      next_rvalid = 1'h0;
      if (req.rd) begin
         next_rvalid = 1'h1;
         if (ctrl_rd) begin
            next_rdata = {24'h00_0000, ctrl};
         end else if (data_rd) begin
            // Blocked reads return zero rather than stale RAM content
            next_rdata = all_enabled ? cur_word : RDATA_RESET; // RULE1 RULE5 RULE8
         end else if (sig_rd) begin
            next_rdata = sig_word; // RULE9
         end else begin
            next_rdata = RDATA_RESET;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= RDATA_RESET;
         rvalid <= RVALID_RESET;
      end else begin
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // Power group: follows the enables one cycle late
   always_comb begin
      next_power_down = ~all_enabled; // RULE3
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ram_power_down <= POWER_DOWN_RESET;
      end else begin
         ram_power_down <= next_power_down;
      end
   end

   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_word
         always_comb begin
            next_mem[i] = mem[i];
            if (write_commit && ptr == ADDR_W'(i)) begin // RULE4 RULE5
               next_mem[i] = req.wdata; // RULE8
            end
         end
         // Contents survive reset; software reloads the table anyway
         always_ff @(posedge clk) begin
            mem[i] <= next_mem[i];
         end
      end
   endgenerate

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Reset and control register
   a_reset_state: assert property ($past(srst)
      |-> ctrl == CTRL_RESET && !rvalid && ram_power_down && rdata == RDATA_RESET)
      else $error("state after reset wrong"); // RULE3
   a_ctrl_write: assert property (ctrl_wr
      |=> ctrl == $past(req.wdata[7:0]))
      else $error("control write lost"); // RULE5
   a_ctrl_read: assert property (ctrl_rd
      |=> rvalid && rdata == {24'h00_0000, $past(ctrl)})
      else $error("control readback wrong"); // RULE5

   // Address pointer
   a_ptr_advance: assert property ((data_access && all_enabled && !ctrl_wr)
      |=> ptr == $past(ptr) + 6'h01)
      else $error("pointer did not advance"); // RULE6
   a_ptr_wrap: assert property ((data_access && all_enabled && ptr == 6'h3f)
      |=> ptr == 6'h00)
      else $error("pointer did not wrap"); // RULE6
   a_ptr_hold: assert property ((data_access && !all_enabled)
      |=> ptr == $past(ptr))
      else $error("pointer moved while disabled"); // RULE10
   a_ptr_static: assert property ((!ctrl_wr && !data_access)
      |=> ptr == $past(ptr))
      else $error("pointer moved without access"); // RULE6

   // RAM contents
   a_access_gate: assert property ((data_wr && !ctrl[ACCESS_BIT])
      |=> mem[$past(ptr)] == $past(cur_word))
      else $error("write with access off"); // RULE1
   a_update_gate: assert property ((data_wr && !ctrl[UPDATE_BIT])
      |=> mem[$past(ptr)] == $past(cur_word))
      else $error("write with update off"); // RULE4
   a_word_keep: assert property (!write_commit
      |=> mem[$past(ptr)] == $past(cur_word))
      else $error("word changed without write"); // RULE4
   a_write_lands: assert property ((data_wr && all_enabled)
      |=> mem[$past(ptr)] == $past(req.wdata))
      else $error("write lost"); // RULE4

   // Power state
   a_power_down: assert property (!all_enabled
      |=> ram_power_down)
      else $error("RAM not powered down"); // RULE3
   a_power_up: assert property (all_enabled
      |=> !ram_power_down)
      else $error("RAM down while enabled"); // RULE3

   // Read data
   a_read_word: assert property ((data_rd && all_enabled)
      |=> rvalid && rdata == $past(cur_word))
      else $error("wrong read word"); // RULE8
   a_read_blocked: assert property ((data_rd && !all_enabled)
      |=> rvalid && rdata == 32'h0000_0000)
      else $error("blocked read leaked"); // RULE1
   a_none_read: assert property (none_rd
      |=> rvalid && rdata == 32'h0000_0000)
      else $error("unmapped read not zero"); // RULE8
   a_rvalid_idle: assert property (!req.rd
      |=> !rvalid && $stable(rdata))
      else $error("read data moved without read"); // RULE8

   // Signature register
   a_sig_read: assert property (sig_rd
      |=> rvalid && rdata == {$past(sig_in.frames), $past(sig_in.crc)})
      else $error("signature mismatch"); // RULE9
   a_sig_static: assert property ((req.wr && req.sel == SEL_SIG)
      |=> ctrl == $past(ctrl))
      else $error("signature write had effect"); // RULE9

   c_stream_write: cover property (write_commit ##2 write_commit ##2 write_commit);
   c_stream_read: cover property ((data_rd && all_enabled) ##1 rvalid);
   c_ptr_wrap: cover property (data_access && all_enabled && ptr == 6'h3f);
   c_blocked: cover property (data_access && !all_enabled);
   c_none_read: cover property (none_rd ##1 rvalid);
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   import dither_ram_pkg::*;
   logic clk, srst, b12, b0, rvalid, ram_power_down;
   reg_req_t req;
   sig_in_t sig;
   logic [31:0] rdata, rnd, mem [64];
   logic [7:0] ctrl;
   int fail_count, total_checks, i, k;
   dither_ram_host_access dut_u (.clk(clk), .srst(srst), .req(req), .panel_ctl_bit12(b12),
      .panel_ctl_bit0(b0), .sig_in(sig), .rdata(rdata), .rvalid(rvalid), .ram_power_down(ram_power_down));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic r, input reg_sel_t s, input logic [31:0] d);
      logic [31:0] exp;
      logic ok;
      ok = ctrl[7] && ctrl[6] && b12 && b0;
      exp = 32'h0;
      if (s == SEL_CTRL) exp = {24'h0, ctrl};
      if (s == SEL_DATA && ok) exp = mem[ctrl[5:0]];
      if (s == SEL_SIG) exp = {sig.frames, sig.crc};
      @(posedge clk);
      req <= '{w, r, s, d};
      @(posedge clk);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      #1;
      if (r) chk_flag(rvalid, 1'h1);
      if (r) chk(rdata, exp);
      if (w && s == SEL_DATA && ok) mem[ctrl[5:0]] = d;
      if (s == SEL_DATA && ok) ctrl[5:0] = ctrl[5:0] + 6'h01;
      if (w && s == SEL_CTRL) ctrl = d[7:0];
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #50000;
      fail_count++;
      tally_and_finish;
   end
   initial begin
      req = '0; srst = 1; b12 = 0; b0 = 0; sig = '0; ctrl = 8'h00; rnd = 32'h8b4e40ed;
      repeat (8) @(posedge clk);
      srst <= 0; b12 <= 1; b0 <= 1;
      #1 chk_flag(ram_power_down, 1'h1);
      acc(1, 0, SEL_CTRL, 32'hc5);
      for (i = 0; i < 64; i++) begin
         rnd = lfsr(rnd);
         acc(1, 0, SEL_DATA, rnd);
      end
      acc(0, 1, SEL_CTRL, 0);
      for (i = 0; i < 64; i++) acc(0, 1, SEL_DATA, 0);
      chk_flag(ram_power_down, 1'h0);
      $display("stream test done");
      // Drop one of the four enables per pass
      for (k = 0; k < 4; k++) begin
         @(posedge clk);
         b12 <= (k != 0);
         b0 <= (k != 1);
         acc(1, 0, SEL_CTRL, (k == 2) ? 32'h45 : (k == 3) ? 32'h85 : 32'hc9);
         acc(1, 0, SEL_DATA, 32'hdead_beef);
         acc(0, 1, SEL_DATA, 0);
         acc(0, 1, SEL_CTRL, 0);
         chk_flag(ram_power_down, 1'h1);
      end
      @(posedge clk);
      b12 <= 1; b0 <= 1;
      acc(1, 0, SEL_CTRL, 32'hc9);
      acc(0, 1, SEL_DATA, 0);
      // Jump to a random word, then an unmapped select
      rnd = lfsr(rnd);
      acc(1, 0, SEL_CTRL, {24'h00_0000, 2'h3, rnd[5:0]});
      acc(0, 1, SEL_DATA, 0);
      acc(0, 1, SEL_CTRL, 0);
      acc(0, 1, SEL_NONE, 0);
      $display("blocked test done");
      rnd = lfsr(rnd);
      @(posedge clk);
      sig <= rnd;
      acc(1, 0, SEL_SIG, ~rnd);
      acc(0, 1, SEL_SIG, 0);
      $display("signature test done");
      tally_and_finish;
   end
endmodule
